// File: src/atd_regs.sv
// Antenna tuning and modulation depth register bank, top level
`include "atd_map.svh"
module atd_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic defaults_i,
  input wire atd_pkg::atd_bus_type bus_i,
  output logic [7:0] rdata_o,
  input wire atd_pkg::atd_tune_type tune_i,
  input wire atd_pkg::atd_depth_type depth_i,
  output logic [7:0] phase_goal_o,
  output logic [5:0] depth_code_o,
  output logic modulated_level_source_o,
  output logic [7:0] modulated_segments_off_o,
  output logic [3:0] tuning_pin_group_one_o,
  output logic [3:0] tuning_pin_group_two_o,
  output logic irq_o
);
  import atd_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] phase_goal_q;
  logic [7:0] depth_ctrl_q;
  logic [7:0] manual_trim_q;
  logic [7:0] manual_mask_q;
  logic [7:0] tune_result_q;
  logic [7:0] depth_result_segments;
  logic [7:0] irq_status_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] nxt_irq_status;
  logic [7:0] tune_value;
  logic [7:0] depth_value;
  logic [7:0] irq_events;
  logic [7:0] nxt_rdata;
  logic [3:0] trim_sel;
  logic [7:0] seg_sel;
  logic we_goal, we_ctrl, we_trim, we_mask;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  assign we_goal = bus_i.wr && (bus_i.addr == `ATD_OFS_PHASE_GOAL);
  assign we_ctrl = bus_i.wr && (bus_i.addr == `ATD_OFS_DEPTH_CTRL);
  assign we_trim = bus_i.wr && (bus_i.addr == `ATD_OFS_MANUAL_TRIM);
  assign we_mask = bus_i.wr && (bus_i.addr == `ATD_OFS_MANUAL_MASK);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Phase goal defaults to bit 7 only
  atd_reg8 #(.RST_VAL(`ATD_RST_PHASE_GOAL), .WMASK(8'hFF)) u_goal (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .we_i(we_goal), .wdata_i(bus_i.wdata), .q_o(phase_goal_q));
  // Bit 0 of depth control is unused
  atd_reg8 #(.RST_VAL(`ATD_RST_ZERO), .WMASK(8'hFE)) u_ctrl (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .we_i(we_ctrl), .wdata_i(bus_i.wdata), .q_o(depth_ctrl_q));
  // Manual trim: source bit 7, pattern 6:3
  atd_reg8 #(.RST_VAL(`ATD_RST_ZERO), .WMASK(8'hF8)) u_trim (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .we_i(we_trim), .wdata_i(bus_i.wdata), .q_o(manual_trim_q));
  // Manual segment mask, one bit per segment
  atd_reg8 #(.RST_VAL(`ATD_RST_ZERO), .WMASK(8'hFF)) u_mask (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .we_i(we_mask), .wdata_i(bus_i.wdata), .q_o(manual_mask_q));

  // ****************************************************************
  // Calibration results
  // ****************************************************************
  // Low three bits read zero; error flag in bit 3
  assign tune_value = {tune_i.trim, tune_i.fail, 3'b000};
  // A failed depth run reports every segment off
  assign depth_value = depth_i.fail ? `ATD_DEPTH_FAIL_MASK
                                    : depth_i.segments;
  atd_result u_tres (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .load_i(tune_i.done), .value_i(tune_value), .q_o(tune_result_q));
  // Calibration only owns the level on the automatic source
  atd_result u_dres (
    .clk_i(clk_i), .reset_i(reset_i), .defaults_i(defaults_i),
    .load_i(depth_i.done), .value_i(depth_value),
    .q_o(depth_result_segments));

  // ****************************************************************
  // Source selection for trim switches and driver segments
  // ****************************************************************
  assign trim_sel = manual_trim_q[`ATD_SRC_BIT]
      ? manual_trim_q[`ATD_MTRIM_MSB:`ATD_MTRIM_LSB]
      : tune_result_q[`ATD_TRIM_MSB:`ATD_TRIM_LSB];
  assign seg_sel = depth_ctrl_q[`ATD_SRC_BIT]
      ? manual_mask_q : depth_result_segments;

  // Outputs registered so pins never glitch on a select change
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tuning_pin_group_one_o <= 4'h0;
      tuning_pin_group_two_o <= 4'h0;
      modulated_segments_off_o <= 8'h00;
      modulated_level_source_o <= 1'b0;
      depth_code_o <= 6'h00;
      phase_goal_o <= `ATD_RST_PHASE_GOAL;
    end else begin
      tuning_pin_group_one_o <= trim_sel;
      tuning_pin_group_two_o <= trim_sel;
      modulated_segments_off_o <= seg_sel;
      modulated_level_source_o <= depth_ctrl_q[`ATD_SRC_BIT];
      depth_code_o <= depth_ctrl_q[`ATD_CODE_MSB:`ATD_CODE_LSB];
      phase_goal_o <= phase_goal_q;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_events = {4'h0, depth_i.done && depth_i.fail, depth_i.done,
                       tune_i.done && tune_i.fail, tune_i.done};
  // Write one to clear; a new event in the same cycle wins
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (bus_i.wr && (bus_i.addr == `ATD_OFS_IRQ_STATUS)) begin
      nxt_irq_status = nxt_irq_status & ~bus_i.wdata;
    end
    nxt_irq_status = nxt_irq_status | irq_events;
  end

  // Status keeps events across a restore command
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_status_ff <= 8'h00;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // Mask, four low bits implemented
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_mask_ff <= 8'h00;
    end else if (bus_i.wr && (bus_i.addr == `ATD_OFS_IRQ_MASK)) begin
      irq_mask_ff <= bus_i.wdata & 8'h0F;
    end
  end

  // Level output from a flop, updated on the same edge as status
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_comb begin
    unique case (bus_i.addr)
      `ATD_OFS_PHASE_GOAL: nxt_rdata = phase_goal_q;
      `ATD_OFS_TUNE_RESULT: nxt_rdata = tune_result_q;
      `ATD_OFS_DEPTH_CTRL: nxt_rdata = depth_ctrl_q;
      `ATD_OFS_DEPTH_RESULT: nxt_rdata = depth_result_segments;
      `ATD_OFS_MANUAL_TRIM: nxt_rdata = manual_trim_q;
      `ATD_OFS_MANUAL_MASK: nxt_rdata = manual_mask_q;
      `ATD_OFS_IRQ_STATUS: nxt_rdata = irq_status_ff;
      `ATD_OFS_IRQ_MASK: nxt_rdata = irq_mask_ff;
      default: nxt_rdata = 8'h00; // Unmapped reads as zero
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (bus_i.rd) begin
      rdata_o <= nxt_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule : atd_regs

// File: src/atd_map.svh
// Register offsets, field positions, reset values of the tuning/depth bank
// ****************************************************************
// Overview of operation
// - Phase goal register, resets to 0x80
// - Tuning trim pattern stored in bits 7:4
// - Selected trim bits drive both pin groups
// - Bit 3 flags failed tuning sequence
// - Result registers clear on reset, defaults
// - Writable registers return to defaults too, IRQ status and mask excepted
// - Bit 7 picks depth result or mask
// - Auto source: calibration sets segment pattern
// - Eight binary weighted segments, 8-bit mask
// - Result bit one disables segment when modulated
// - Failed depth calibration loads all ones
// - Trim source bit picks result or manual
// - Manual mask bit disables segment when modulated
// ****************************************************************
`ifndef ATD_MAP_SVH
`define ATD_MAP_SVH
`define ATD_OFS_PHASE_GOAL 8'h22
`define ATD_OFS_TUNE_RESULT 8'h23
`define ATD_OFS_DEPTH_CTRL 8'h24
`define ATD_OFS_DEPTH_RESULT 8'h25
`define ATD_OFS_MANUAL_TRIM 8'h21
`define ATD_OFS_MANUAL_MASK 8'h26
`define ATD_OFS_IRQ_STATUS 8'h30
`define ATD_OFS_IRQ_MASK 8'h31
`define ATD_RST_PHASE_GOAL 8'h80
`define ATD_RST_ZERO 8'h00
`define ATD_DEPTH_FAIL_MASK 8'hFF
`define ATD_TRIM_MSB 7
`define ATD_TRIM_LSB 4
`define ATD_TUNE_ERR_BIT 3
`define ATD_SRC_BIT 7
`define ATD_CODE_MSB 6
`define ATD_CODE_LSB 1
`define ATD_MTRIM_MSB 6
`define ATD_MTRIM_LSB 3
`define ATD_IRQ_TUNE_DONE 0
`define ATD_IRQ_TUNE_FAIL 1
`define ATD_IRQ_DEPTH_DONE 2
`define ATD_IRQ_DEPTH_FAIL 3
`endif

// File: src/atd_pkg.sv
// Types shared by the tuning and depth register bank
package atd_pkg;
  // Result of one antenna tuning run
  typedef struct packed {
    logic done;
    logic fail;
    logic [3:0] trim;
  } atd_tune_type;
  // Result of one depth calibration run
  typedef struct packed {
    logic done;
    logic fail;
    logic [7:0] segments;
  } atd_depth_type;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } atd_bus_type;
endpackage : atd_pkg

// File: src/atd_reg8.sv
// One 8-bit software register with write mask and default reload
`include "atd_map.svh"
module atd_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic defaults_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  // Unwritable bits stay at zero
  always_ff @(posedge clk_i) begin
    if (reset_i || defaults_i) begin
      q_o <= RST_VAL;
    end else if (we_i) begin
      q_o <= wdata_i & WMASK;
    end
  end
endmodule : atd_reg8

// File: src/atd_result.sv
// Result register: loaded by hardware, cleared on reset or defaults
module atd_result (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic defaults_i,
  input wire logic load_i,
  input wire logic [7:0] value_i,
  output logic [7:0] q_o
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  // Defaults win: a restore command wipes a result in flight
  always_ff @(posedge clk_i) begin
    if (reset_i || defaults_i) begin
      q_o <= 8'h00;
    end else if (load_i) begin
      q_o <= value_i;
    end
  end
endmodule : atd_result

// File: verification/atd_cal_model.sv
// Stand-in for the calibration engines behind the bank
module atd_cal_model (
  input wire logic clk_i,
  input wire atd_pkg::atd_tune_type tune_cmd_i,
  input wire atd_pkg::atd_depth_type depth_cmd_i,
  output atd_pkg::atd_tune_type tune_o,
  output atd_pkg::atd_depth_type depth_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One cycle late, like a real engine finishing after the request
  always_ff @(posedge clk_i) begin
    tune_o <= tune_cmd_i;
    depth_o <= depth_cmd_i;
  end
endmodule : atd_cal_model

// File: verification/atd_regs_sva.sv
// Port checker for the tuning and depth register bank
module atd_regs_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic defaults_i,
  input wire atd_pkg::atd_bus_type bus_i,
  input wire logic [7:0] rdata_o,
  input wire atd_pkg::atd_tune_type tune_i,
  input wire atd_pkg::atd_depth_type depth_i,
  input wire logic [7:0] phase_goal_o,
  input wire logic [5:0] depth_code_o,
  input wire logic modulated_level_source_o,
  input wire logic [7:0] modulated_segments_off_o,
  input wire logic [3:0] tuning_pin_group_one_o,
  input wire logic [3:0] tuning_pin_group_two_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Outputs lag registers by one cycle, so checks look two edges on
  a_pins_equal: assert property (tuning_pin_group_one_o ==
    tuning_pin_group_two_o) else $error("pin groups differ");
  a_goal_default: assert property (defaults_i |-> ##2
    phase_goal_o == 8'h80) else $error("goal not restored");
  a_src_default: assert property (defaults_i |-> ##2
    !modulated_level_source_o && depth_code_o == 6'h00)
    else $error("depth control not restored");
  a_segs_cleared: assert property (defaults_i |-> ##2
    modulated_segments_off_o == 8'h00) else $error("segs not cleared");
  a_pins_cleared: assert property (defaults_i |-> ##2
    tuning_pin_group_one_o == 4'h0) else $error("pins not cleared");
  a_src_write: assert property (bus_i.wr && bus_i.addr == 8'h24 &&
    !defaults_i |-> ##2 {1'b0, modulated_level_source_o, depth_code_o}
    == ($past(bus_i.wdata, 2) >> 1)) else $error("source not applied");
  a_depth_fail: assert property (depth_i.done && depth_i.fail &&
    !defaults_i |-> ##2 (modulated_level_source_o ||
    modulated_segments_off_o == 8'hFF)) else $error("fail not all ones");
  a_depth_load: assert property (depth_i.done && !depth_i.fail &&
    !defaults_i |-> ##2 (modulated_level_source_o ||
    modulated_segments_off_o == $past(depth_i.segments, 2)))
    else $error("depth result not applied");
  c_fail: cover property (depth_i.done && depth_i.fail);
  c_dflt: cover property (defaults_i);
  c_irq: cover property (irq_o);
endmodule : atd_regs_sva

// File: verification/atd_regs_tb_top.sv
// Self-checking bench for the tuning and depth register bank
module atd_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import atd_pkg::*;
  logic clk_i = 0, reset_i = 1, defaults_i = 0, src, irq_o, rd_q = 0;
  atd_bus_type bus_i = '0;
  atd_tune_type tune_cmd = '0, tune_i;
  atd_depth_type depth_cmd = '0, depth_i;
  logic [7:0] rdata_o, phase_goal_o, segs, rnd = 8'h25, q[$];
  logic [5:0] depth_code_o;
  logic [3:0] pin1, pin2;
  int n_mismatch = 0, n_tests = 0;
  atd_regs dut (.clk_i, .reset_i, .defaults_i, .bus_i, .rdata_o, .tune_i,
    .depth_i, .phase_goal_o, .depth_code_o, .modulated_level_source_o(src),
    .modulated_segments_off_o(segs), .tuning_pin_group_one_o(pin1),
    .tuning_pin_group_two_o(pin2), .irq_o);
  atd_cal_model model (.clk_i, .tune_cmd_i(tune_cmd),
    .depth_cmd_i(depth_cmd), .tune_o(tune_i), .depth_o(depth_i));
  // ****************************************
  // Stimulus and checking helpers
  // ****************************************
  initial forever #25 clk_i = ~clk_i;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) bus_i <= '0;
  endtask : wr
  // Expected read data queued here, compared by the monitor below
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    q.push_back(e);
    @(posedge clk_i) bus_i <= '0;
  endtask : rd
  // Engine pulse, then wait until the pins have followed
  task automatic cal(input atd_tune_type t, input atd_depth_type d);
    @(posedge clk_i) tune_cmd <= t;
    depth_cmd <= d;
    @(posedge clk_i) tune_cmd <= '0;
    depth_cmd <= '0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : cal
  task automatic dflt_regs();
    rd(8'h22, 8'h80);
    for (int a = 8'h23; a <= 8'h25; a++) rd(8'(a), 8'h00);
    rd(8'h21, 8'h00);
  endtask : dflt_regs
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // Read data stands only one cycle after the strobe edge
  always @(posedge clk_i) begin
    rd_q <= bus_i.rd;
  end
  // Look mid-cycle, clear of the edge that drops the data again
  always @(negedge clk_i) begin
    if (rd_q) chk("rdata", q.pop_front(), rdata_o);
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    dflt_regs();
    rd(8'h40, 8'h00);
    $display("reset values done");
    rnd = lfsr(rnd);
    wr(8'h22, rnd);
    rd(8'h22, rnd);
    chk("goal", rnd, phase_goal_o);
    wr(8'h24, rnd);
    rd(8'h24, rnd & 8'hFE);
    chk("code", {2'b00, rnd[6:1]}, {2'b00, depth_code_o});
    wr(8'h23, 8'hFF);
    rd(8'h23, 8'h00);
    wr(8'h24, 8'h00);
    wr(8'h31, 8'h0F);
    $display("register access done");
    rnd = lfsr(rnd);
    cal('{1'b1, 1'b1, rnd[3:0]}, '0);
    chk("pins", {rnd[3:0], rnd[3:0]}, {pin1, pin2});
    chk("irq", 8'h01, {7'h00, irq_o});
    rd(8'h23, {rnd[3:0], 4'h8});
    rd(8'h30, 8'h03);
    wr(8'h30, 8'h03);
    @(posedge clk_i) #1 chk("irq", 8'h00, {7'h00, irq_o});
    wr(8'h31, 8'h00);
    cal('0, '{1'b1, 1'b1, rnd});
    chk("segs", 8'hFF, segs);
    chk("irq", 8'h00, {7'h00, irq_o});
    rd(8'h30, 8'h0C);
    rd(8'h25, 8'hFF);
    rnd = lfsr(rnd);
    cal('0, '{1'b1, 1'b0, rnd});
    chk("segs", rnd, segs);
    $display("calibration results done");
    wr(8'h26, ~rnd);
    wr(8'h24, 8'h80);
    wr(8'h21, 8'hD0);
    repeat (2) @(posedge clk_i);
    #1 chk("mask", ~rnd, segs);
    chk("manual", 8'hAA, {pin1, pin2});
    @(posedge clk_i) defaults_i <= 1'b1;
    @(posedge clk_i) defaults_i <= 1'b0;
    dflt_regs();
    repeat (3) @(posedge clk_i);
    $display("manual and defaults done");
    complete_run();
  end
endmodule : atd_regs_tb_top
bind atd_regs atd_regs_sva sva (.clk_i, .reset_i, .defaults_i, .bus_i,
  .rdata_o, .tune_i, .depth_i, .phase_goal_o, .depth_code_o,
  .modulated_level_source_o, .modulated_segments_off_o,
  .tuning_pin_group_one_o, .tuning_pin_group_two_o, .irq_o);
